//--- gpio_fgh_pkg.sv
// shared constants for the three small gpio ports
package gpio_fgh_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses on the plain register port)
	// ------------------------------------------------------------
	localparam int addr_width = 8;
	localparam logic [7:0] port_seven_data_offset = 8'h09;
	localparam logic [7:0] port_three_data_offset = 8'h0a;
	localparam logic [7:0] port_two_data_offset = 8'h0b;
	localparam logic [7:0] port_three_direction_offset = 8'h0e;
	localparam logic [7:0] port_seven_direction_offset = 8'h0d;
	localparam logic [7:0] port_two_direction_offset = 8'h0f;
	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int seven_width = 7;
	localparam int three_width = 3;
	localparam int two_width = 2;
	localparam logic [7:0] direction_reset = 8'h00;
	localparam logic [7:0] read_unmapped = 8'h00;
endpackage

//--- gpio_ports_f_g_h.sv
// three small gpio ports with timer and keyboard pin hand-over
// Operation
// - the seven-pin port has a data latch bit and a direction bit per pin.
// - the three-pin and two-pin ports each have a data latch and direction bit per pin.
// - reset leaves every data latch unchanged.
// - a direction bit of 1 enables the pin driver and 0 leaves the pin an input.
// - reset clears every implemented direction bit so all pins not owned by a timer start as inputs.
// - a data read returns the latch for output pins and the pin level for input pins.
// - data latch writes are taken whatever the direction, without touching input pins.
// - pins 3..0 of the seven-pin port go to timer a channels 3..0 when enabled there.
// - pins 4 and 5 of the seven-pin port go to timer b channels 0 and 1 when enabled there.
// - on a timer-owned pin the direction bit steers only the read selection.
// - keyboard enable bits 2..0 make the three-pin port pins interrupt inputs.
// - keyboard enable bits 4..3 make the two-pin port pins interrupt inputs.
// - only bits 2..0 of the three-pin direction register exist; the rest read 0.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module gpio_ports_f_g_h
	import gpio_fgh_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [gpio_fgh_pkg::addr_width-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic [gpio_fgh_pkg::seven_width-1:0] seven_pin_in,
	output logic [gpio_fgh_pkg::seven_width-1:0] seven_pin_out,
	output logic [gpio_fgh_pkg::seven_width-1:0] seven_pin_oe,
	input wire logic [gpio_fgh_pkg::three_width-1:0] three_pin_in,
	output logic [gpio_fgh_pkg::three_width-1:0] three_pin_out,
	output logic [gpio_fgh_pkg::three_width-1:0] three_pin_oe,
	input wire logic [gpio_fgh_pkg::two_width-1:0] two_pin_in,
	output logic [gpio_fgh_pkg::two_width-1:0] two_pin_out,
	output logic [gpio_fgh_pkg::two_width-1:0] two_pin_oe,
	input wire logic [3:0] timer_a_channel_io_enable,
	input wire logic [3:0] timer_a_channel_oe,
	input wire logic [3:0] timer_a_channel_out,
	output logic [3:0] timer_a_channel_pins,
	input wire logic [1:0] timer_b_channel_io_enable,
	input wire logic [1:0] timer_b_channel_oe,
	input wire logic [1:0] timer_b_channel_out,
	output logic [1:0] timer_b_channel_pins,
	input wire logic [4:0] keyboard_pin_irq_enable,
	output logic [4:0] keyboard_pin_level
);
	import gpio_fgh_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [seven_width-1:0] seven_data;
		logic [three_width-1:0] three_data;
		logic [two_width-1:0] two_data;
		logic [seven_width-1:0] seven_dir;
		logic [three_width-1:0] three_dir;
		logic [two_width-1:0] two_dir;
		logic [7:0] rdata;
	} port_state_type;
	port_state_type state, next_state;

	logic [seven_width-1:0] seven_level;
	logic [three_width-1:0] three_level;
	logic [two_width-1:0] two_level;
	logic [seven_width-1:0] seven_owned;
	logic [seven_width-1:0] seven_owner_oe;
	logic [seven_width-1:0] seven_owner_out;

	// read selection: latch where direction is 1, pin level otherwise
	function automatic logic [7:0] pick(input logic [7:0] latch, input logic [7:0] dir,
		input logic [7:0] level);
		pick = (latch & dir) | (level & ~dir);
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	pin_sync #(.width(seven_width)) sync_seven (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_raw(seven_pin_in),
		.pin_level(seven_level)
	);
	pin_sync #(.width(three_width)) sync_three (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_raw(three_pin_in),
		.pin_level(three_level)
	);
	pin_sync #(.width(two_width)) sync_two (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_raw(two_pin_in),
		.pin_level(two_level)
	);

	// ------------------------------------------------------------
	// ownership of the seven-pin port by the timers
	// ------------------------------------------------------------
	// pin 6 has no alternate owner
	assign seven_owned = {1'b0, timer_b_channel_io_enable, timer_a_channel_io_enable};
	assign seven_owner_oe = {1'b0, timer_b_channel_oe, timer_a_channel_oe};
	assign seven_owner_out = {1'b0, timer_b_channel_out, timer_a_channel_out};
	// timers see the synchronised pin level for input capture
	assign timer_a_channel_pins = seven_level[3:0];
	assign timer_b_channel_pins = seven_level[5:4];
	assign keyboard_pin_level = {two_level, three_level};

	pin_mux #(.width(seven_width)) mux_seven (
		.latch(state.seven_data),
		.direction(state.seven_dir),
		.owned(seven_owned),
		.owner_oe(seven_owner_oe),
		.owner_out(seven_owner_out),
		.pin_out(seven_pin_out),
		.pin_oe(seven_pin_oe)
	);
	// keyboard pins are pure inputs while enabled
	pin_mux #(.width(three_width)) mux_three (
		.latch(state.three_data),
		.direction(state.three_dir),
		.owned(keyboard_pin_irq_enable[2:0]),
		.owner_oe(3'h0),
		.owner_out(3'h0),
		.pin_out(three_pin_out),
		.pin_oe(three_pin_oe)
	);
	pin_mux #(.width(two_width)) mux_two (
		.latch(state.two_data),
		.direction(state.two_dir),
		.owned(keyboard_pin_irq_enable[4:3]),
		.owner_oe(2'h0),
		.owner_out(2'h0),
		.pin_out(two_pin_out),
		.pin_oe(two_pin_oe)
	);

	// ------------------------------------------------------------
	// register writes and reads
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.rdata = read_unmapped;
		if (reg_write) begin
			case (reg_addr)
				// latch writes never look at direction
				port_seven_data_offset: next_state.seven_data = reg_wdata[6:0];
				port_three_data_offset: next_state.three_data = reg_wdata[2:0];
				port_two_data_offset: next_state.two_data = reg_wdata[1:0];
				port_seven_direction_offset: next_state.seven_dir = reg_wdata[6:0];
				port_three_direction_offset: next_state.three_dir = reg_wdata[2:0];
				port_two_direction_offset: next_state.two_dir = reg_wdata[1:0];
				default: next_state.rdata = read_unmapped;
			endcase
		end
		if (reg_read) begin
			// direction still picks latch or pin on owned pins
			case (reg_addr)
				port_seven_data_offset: next_state.rdata = pick({1'b0, state.seven_data},
					{1'b0, state.seven_dir}, {1'b0, seven_level});
				port_three_data_offset: next_state.rdata = pick({5'h00, state.three_data},
					{5'h00, state.three_dir}, {5'h00, three_level});
				port_two_data_offset: next_state.rdata = pick({6'h00, state.two_data},
					{6'h00, state.two_dir}, {6'h00, two_level});
				port_seven_direction_offset: next_state.rdata = {1'b0, state.seven_dir};
				port_three_direction_offset: next_state.rdata = {5'h00, state.three_dir};
				port_two_direction_offset: next_state.rdata = {6'h00, state.two_dir};
				default: next_state.rdata = read_unmapped;
			endcase
		end
	end

	// one register process for the whole state; reset clears direction and read data only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			// latches are left out here so their content survives a reset
			state.seven_dir <= direction_reset[6:0];
			state.three_dir <= direction_reset[2:0];
			state.two_dir <= direction_reset[1:0];
			state.rdata <= read_unmapped;
		end else begin
			state <= next_state;
		end
	end
	assign reg_rdata = state.rdata;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_dir_write(logic [7:0] a);
		reg_write && reg_addr == a;
	endsequence

	property p_reset_dir;
		@(posedge clk) $fell(sys_rst) |-> (seven_pin_oe & ~seven_owned) == 7'h00;
	endproperty
	a_reset_dir: assert property (p_reset_dir) else $error("direction not cleared");

	property p_oe_follows_dir;
		@(posedge clk) disable iff (sys_rst)
		s_dir_write(port_seven_direction_offset) ##1 (seven_owned == 7'h00)
		|-> seven_pin_oe == $past(reg_wdata[6:0]);
	endproperty
	a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("enable not from dir");

	property p_latch_drives;
		@(posedge clk) disable iff (sys_rst)
		s_dir_write(port_two_data_offset) ##1 (keyboard_pin_irq_enable[4:3] == 2'h0)
		|-> two_pin_out == $past(reg_wdata[1:0]);
	endproperty
	a_latch_drives: assert property (p_latch_drives) else $error("latch write lost");

	property p_read_select;
		@(posedge clk) disable iff (sys_rst)
		reg_read && reg_addr == port_three_data_offset && !reg_write |=> reg_rdata ==
		{5'h00, ($past(state.three_data) & $past(state.three_dir))
		| ($past(three_level) & ~$past(state.three_dir))};
	endproperty
	a_read_select: assert property (p_read_select) else $error("bad read select");

	property p_three_dir_high;
		@(posedge clk) disable iff (sys_rst)
		reg_read && reg_addr == port_three_direction_offset |=> reg_rdata[7:3] == 5'h00;
	endproperty
	a_three_dir_high: assert property (p_three_dir_high) else $error("reserved bits set");

	property p_timer_a_owns;
		@(posedge clk) disable iff (sys_rst)
		timer_a_channel_io_enable[0] |-> seven_pin_oe[0] == timer_a_channel_oe[0]
		&& seven_pin_out[0] == timer_a_channel_out[0];
	endproperty
	a_timer_a_owns: assert property (p_timer_a_owns) else $error("timer a not owner");

	property p_timer_b_owns;
		@(posedge clk) disable iff (sys_rst)
		timer_b_channel_io_enable[1] |-> seven_pin_oe[5] == timer_b_channel_oe[1];
	endproperty
	a_timer_b_owns: assert property (p_timer_b_owns) else $error("timer b not owner");

	property p_kbd_input;
		@(posedge clk) disable iff (sys_rst)
		keyboard_pin_irq_enable[2] |-> !three_pin_oe[2];
	endproperty
	a_kbd_input: assert property (p_kbd_input) else $error("keyboard pin driven");

	property p_kbd_two;
		@(posedge clk) disable iff (sys_rst)
		keyboard_pin_irq_enable[3] |-> !two_pin_oe[0];
	endproperty
	a_kbd_two: assert property (p_kbd_two) else $error("keyboard pin driven");

	property p_kbd_two_high;
		@(posedge clk) disable iff (sys_rst)
		keyboard_pin_irq_enable[4] |-> !two_pin_oe[1];
	endproperty
	a_kbd_two_high: assert property (p_kbd_two_high) else $error("keyboard pin driven");

	// the low timer b channel owns pin 4 for both enable and value
	property p_timer_b_low;
		@(posedge clk) disable iff (sys_rst)
		timer_b_channel_io_enable[0] |-> seven_pin_oe[4] == timer_b_channel_oe[0]
		&& seven_pin_out[4] == timer_b_channel_out[0];
	endproperty
	a_timer_b_low: assert property (p_timer_b_low) else $error("timer b low lost");

	// a read is answered for one cycle only, then the port falls back to zero
	property p_rdata_idle;
		@(posedge clk) disable iff (sys_rst)
		!reg_read |=> reg_rdata == read_unmapped;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

	sequence s_read(logic [7:0] a);
		reg_read && reg_addr == a;
	endsequence

	// with every direction bit set the read shows the latch, never the pad
	property p_latch_read;
		@(posedge clk) disable iff (sys_rst)
		s_read(port_seven_data_offset) ##0 (state.seven_dir == 7'h7f)
		|=> reg_rdata == {1'b0, $past(state.seven_data)};
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("latch not read");

	// an unowned three-pin latch write reaches the pad value one cycle later
	property p_three_drives;
		@(posedge clk) disable iff (sys_rst)
		s_dir_write(port_three_data_offset) ##1 (keyboard_pin_irq_enable[2:0] == 3'h0)
		|-> three_pin_out == $past(reg_wdata[2:0]);
	endproperty
	a_three_drives: assert property (p_three_drives) else $error("three latch lost");

	property p_two_oe_dir;
		@(posedge clk) disable iff (sys_rst)
		s_dir_write(port_two_direction_offset) ##1 (keyboard_pin_irq_enable[4:3] == 2'h0)
		|-> two_pin_oe == $past(reg_wdata[1:0]);
	endproperty
	a_two_oe_dir: assert property (p_two_oe_dir) else $error("two enable wrong");

	// two sampled edges in reset: the async clear has already landed by then
	sequence s_reset_held;
		sys_rst ##1 sys_rst;
	endsequence

	property p_reset_hold;
		@(posedge clk)
		s_reset_held |-> state.seven_dir == 7'h00 && state.three_dir == 3'h0
		&& state.two_dir == 2'h0;
	endproperty
	a_reset_hold: assert property (p_reset_hold) else $error("direction not held");
endmodule

//--- pin_mux.sv
// per-pin ownership mux between port latch and an owning module
`timescale 1ns/1ps
module pin_mux #(
	parameter int width = 1
) (
	input wire logic [width-1:0] latch,
	input wire logic [width-1:0] direction,
	input wire logic [width-1:0] owned,
	input wire logic [width-1:0] owner_oe,
	input wire logic [width-1:0] owner_out,
	output logic [width-1:0] pin_out,
	output logic [width-1:0] pin_oe
);
	// owner replaces both enable and value; otherwise latch and direction
	always_comb begin
		for (int i = 0; i < width; i++) begin
			pin_oe[i] = owned[i] ? owner_oe[i] : direction[i];
			pin_out[i] = owned[i] ? owner_out[i] : latch[i];
		end
	end
endmodule

//--- pin_partner.sv
// outside world of one port: pads resolving port drive against external drive
`timescale 1ns/1ps
module pin_partner #(
	parameter int width = 1
) (
	input wire logic [width-1:0] drive_out,
	input wire logic [width-1:0] drive_oe,
	input wire logic [width-1:0] ext_level,
	output logic [width-1:0] pin_level
);
	// ------------------------------------------------------------
	// pad resolution
	// ------------------------------------------------------------
	// a driven pad follows the port, an undriven one the outside driver
	assign pin_level = (drive_oe & drive_out) | (~drive_oe & ext_level);
endmodule

//--- pin_sync.sv
// three-stage synchroniser with agreement filter for pin levels
`timescale 1ns/1ps
module pin_sync #(
	parameter int width = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [width-1:0] pin_raw,
	output logic [width-1:0] pin_level
);
	typedef struct packed {
		logic [width-1:0] s1;
		logic [width-1:0] s2;
		logic [width-1:0] s3;
		logic [width-1:0] level;
	} sync_state_type;
	sync_state_type state, next_state;
	// ------------------------------------------------------------
	// next state: the level follows only when stages two and three agree
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.s1 = pin_raw;
		next_state.s2 = state.s1;
		next_state.s3 = state.s2;
		for (int i = 0; i < width; i++) begin
			if (state.s2[i] == state.s3[i]) begin
				next_state.level[i] = state.s3[i];
			end
		end
	end
	// registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign pin_level = state.level;
endmodule

//--- tb.sv
// self-checking bench for the three small gpio ports
`timescale 1ns/1ps
module tb;
	import gpio_fgh_pkg::*;
	logic clk = 0, sys_rst = 1, reg_write = 0, reg_read = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [6:0] s_in, s_out, s_oe, s_ext = 7'h00;
	logic [2:0] t_in, t_out, t_oe, t_ext = 3'h0;
	logic [1:0] w_in, w_out, w_oe, w_ext = 2'h0;
	logic [3:0] ta_en = 4'h0, ta_oe = 4'h0, ta_out = 4'h0, ta_pins;
	logic [1:0] tb_en = 2'h0, tb_oe = 2'h0, tb_out = 2'h0, tb_pins;
	logic [4:0] kb_en = 5'h00, kb_lvl;
	int num_errors = 0, compares = 0;
	// ------------------------------------------------------------
	// clock, design and pads
	// ------------------------------------------------------------
	always #4 clk = ~clk;
	gpio_ports_f_g_h DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .seven_pin_in(s_in), .seven_pin_out(s_out),
		.seven_pin_oe(s_oe), .three_pin_in(t_in), .three_pin_out(t_out),
		.three_pin_oe(t_oe), .two_pin_in(w_in), .two_pin_out(w_out), .two_pin_oe(w_oe),
		.timer_a_channel_io_enable(ta_en), .timer_a_channel_oe(ta_oe),
		.timer_a_channel_out(ta_out), .timer_a_channel_pins(ta_pins),
		.timer_b_channel_io_enable(tb_en), .timer_b_channel_oe(tb_oe),
		.timer_b_channel_out(tb_out), .timer_b_channel_pins(tb_pins),
		.keyboard_pin_irq_enable(kb_en), .keyboard_pin_level(kb_lvl));
	pin_partner #(.width(7)) pads_seven (.drive_out(s_out), .drive_oe(s_oe),
		.ext_level(s_ext), .pin_level(s_in));
	pin_partner #(.width(3)) pads_three (.drive_out(t_out), .drive_oe(t_oe),
		.ext_level(t_ext), .pin_level(t_in));
	pin_partner #(.width(2)) pads_two (.drive_out(w_out), .drive_oe(w_oe),
		.ext_level(w_ext), .pin_level(w_in));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe, then fall to 0
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk8("reg_rdata", exp, reg_rdata);
		@(posedge clk);
		#1 chk8("reg_rdata idle", 8'h00, reg_rdata);
	endtask
	// pad levels pass a synchroniser and filter of at most four cycles
	task automatic settle;
		repeat (6) @(posedge clk);
		#1;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_state;
		rd(port_seven_direction_offset, 8'h00);
		rd(port_three_direction_offset, 8'h00);
		rd(port_two_direction_offset, 8'h00);
		chk8("oe", 8'h00, {s_oe, |{t_oe, w_oe}});
	endtask
	task automatic t_seven;
		s_ext <= 7'h2a;
		wr(port_seven_data_offset, 8'h55);
		settle;
		chk8("seven oe", 8'h00, {1'b0, s_oe});
		rd(port_seven_data_offset, 8'h2a);
		wr(port_seven_direction_offset, 8'h0f);
		chk8("seven oe", 8'h0f, {1'b0, s_oe});
		chk8("seven out", 8'h05, {4'h0, s_out[3:0]});
		rd(port_seven_data_offset, 8'h25);
		wr(port_seven_direction_offset, 8'hff);
		rd(port_seven_direction_offset, 8'h7f);
		rd(port_seven_data_offset, 8'h55);
	endtask
	task automatic t_small;
		t_ext <= 3'b101;
		w_ext <= 2'b10;
		wr(port_three_data_offset, 8'h02);
		wr(port_two_data_offset, 8'h01);
		settle;
		rd(port_three_data_offset, 8'h05);
		rd(port_two_data_offset, 8'h02);
		wr(port_three_direction_offset, 8'hff);
		rd(port_three_direction_offset, 8'h07);
		wr(port_two_direction_offset, 8'hff);
		rd(port_two_direction_offset, 8'h03);
		rd(port_three_data_offset, 8'h02);
		rd(port_two_data_offset, 8'h01);
		chk8("small pins", 8'h7b, {1'b0, t_oe, t_out[1:0], w_oe[0], w_out[0]});
	endtask
	task automatic t_reset_keeps;
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		#1 chk8("oe after reset", 8'h00, {1'b0, s_oe | {t_oe, 2'b00, w_oe}});
		wr(port_seven_direction_offset, 8'h7f);
		wr(port_three_direction_offset, 8'h07);
		wr(port_two_direction_offset, 8'h03);
		rd(port_seven_data_offset, 8'h55);
		rd(port_three_data_offset, 8'h02);
		rd(port_two_data_offset, 8'h01);
	endtask
	task automatic t_timers;
		s_ext <= 7'h00;
		@(posedge clk);
		ta_en <= 4'hf;
		ta_oe <= 4'b0011;
		ta_out <= 4'b1010;
		tb_en <= 2'b11;
		tb_oe <= 2'b01;
		tb_out <= 2'b11;
		@(posedge clk);
		#1 chk8("seven oe", 8'h53, {1'b0, s_oe});
		chk8("seven out", 8'h7a, {1'b0, s_out});
		rd(port_seven_data_offset, 8'h55);
		wr(port_seven_direction_offset, 8'h00);
		chk8("seven oe", 8'h13, {1'b0, s_oe});
		settle;
		rd(port_seven_data_offset, 8'h12);
		chk8("timer pins", 8'h12, {2'b00, tb_pins, ta_pins});
		@(posedge clk);
		ta_en <= 4'h0;
		tb_en <= 2'h0;
		@(posedge clk);
		#1 chk8("seven oe released", 8'h00, {1'b0, s_oe});
	endtask
	task automatic t_keyboard;
		@(posedge clk);
		kb_en <= 5'h1f;
		t_ext <= 3'b110;
		w_ext <= 2'b01;
		@(posedge clk);
		#1 chk8("kb pins", 8'h00, {t_oe, t_out, w_oe});
		settle;
		chk8("kb level", 8'h0e, {3'b000, kb_lvl});
		rd(port_three_data_offset, 8'h02);
		@(posedge clk);
		kb_en <= 5'b01010;
		@(posedge clk);
		#1 chk8("kb partial oe", 8'h16, {3'b000, t_oe, w_oe});
	endtask
	task automatic t_unmapped;
		wr(8'h20, 8'hff);
		rd(8'h20, read_unmapped);
		rd(8'h0c, read_unmapped);
		rd(port_seven_direction_offset, 8'h00);
	endtask
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset_state;
		t_seven;
		t_small;
		t_reset_keeps;
		t_timers;
		t_keyboard;
		t_unmapped;
		give_verdict;
	end
	// a hung run is cut short and counted as a mismatch
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		give_verdict;
	end
endmodule
